// [fgc_pkg.sv]
package fgc_pkg;
   // Register bus geometry
   localparam int AW = 8;
   localparam int DW = 16;
   // Register addresses, each register is one 16-bit word
   localparam logic [7:0] ADDR_VCELL = 8'h02;
   localparam logic [7:0] ADDR_SOC = 8'h04;
   localparam logic [7:0] ADDR_MODE = 8'h06;
   localparam logic [7:0] ADDR_VERSION = 8'h08;
   localparam logic [7:0] ADDR_CONFIG = 8'h0C;
   localparam logic [7:0] ADDR_COMMAND = 8'hFE;
   // Command values and reset values
   localparam logic [15:0] MODE_QUICK_START = 16'h4000;
   localparam logic [15:0] CMD_FULL_RESET = 16'h0054;
   localparam logic [15:0] CONFIG_RST = 16'h971C;
   localparam logic [15:0] VERSION_ID = 16'h0A01; // Arbitrary value
   localparam logic [15:0] RDATA_IDLE = 16'h0000;
   // Setup register fields in the low byte, and the SOC percent field from bit 8
   localparam int CFG_SLEEP_BIT = 7;
   localparam int CFG_ALERT_BIT = 5;
   localparam int CFG_THR_LSB = 0;
   localparam int CFG_THR_W = 5;
   localparam int SOC_PCT_LSB = 8;
   // Rest interval assumed by the gauge at every restart, in minutes
   localparam int REST_ASSUME_MIN = 30;
   // Bus-low sleep timing
   localparam int CLK_KHZ = 50000;
   localparam int BUS_LOW_MS = 2500;
   localparam int BUS_LOW_CYC = BUS_LOW_MS * CLK_KHZ;
   localparam int CNT_W = 27;
   // Pin synchroniser layout
   localparam int SYNC_N = 3;
   localparam int PIN_N = 3;
   localparam int IN_QS = 0;
   localparam int IN_SCL = 1;
   localparam int IN_SDA = 2;
   // Sleep modes
   typedef enum logic [1:0] {FGC_ACTIVE, FGC_SLEEP_BUS, FGC_SLEEP_SW} fgc_sleep_e;
endpackage : fgc_pkg

// [fgc_fuel_gauge_control.sv]
// Summary of operation
// - Rising edge on quick_start_pin restarts gauge calculations like power-up.
// - Writing 4000h to the mode register performs the same quick-start restart.
// - Restart assumes 30 minutes of rest; first conversion seeds the estimate.
// - Alert triggers when charge falls below the setup threshold field.
// - A triggered alert drives low_charge_alert low and sets the alert flag.
// - Alert output stays low until software writes the flag to zero.
// - Clearing while still below threshold gives no new alert; must rise first.
// - Alert is armed from power-up; first low result alerts at once.
// - Entering sleep leaves a pending alert flag and output untouched.
// - Both bus lines held low long enough put the device to sleep.
// - Sleep halts all processing; wake resumes from the same state.
// - Bus-low sleep ends at once on a rising edge of either line.
// - Writing the sleep bit to one forces sleep.
// - Sleep-bit sleep ends only when the bit is cleared or on reset.
// - Writing 0054h to the command register fully resets the device.
// - The full reset acts right after the command word completes.
// - The final byte of the reset command is not acknowledged.
// - Writes not carrying all 16 bits are ignored entirely.
// - Mode values other than the listed command have no effect.
module fgc_fuel_gauge_control #(
   parameter int unsigned BUS_LOW_CYC_P = fgc_pkg::BUS_LOW_CYC
) (
   input wire logic core_clk,
   input wire logic rst_n,
   input wire logic ce,
   input wire logic [fgc_pkg::AW-1:0] reg_addr,
   input wire logic [fgc_pkg::DW-1:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   input wire logic reg_wr_whole,
   output logic [fgc_pkg::DW-1:0] reg_rdata,
   input wire logic quick_start_pin,
   input wire logic scl_in,
   input wire logic sda_in,
   input wire logic [fgc_pkg::DW-1:0] soc_value,
   input wire logic soc_update,
   output logic gauge_restart,
   output logic gauge_seed_rest,
   output logic gauge_halt,
   output logic device_reset,
   output logic reset_cmd_nack,
   output logic low_charge_alert_n
);
   import fgc_pkg::*;

   ////////////////////////////////////////////////////////////////////////////////
   // Pin synchronisers: three flops, level changes once stages two and three agree
   logic [PIN_N-1:0] pin_in;
   logic [PIN_N-1:0] lvl_v;
   logic [PIN_N-1:0] rise_v;
   assign pin_in = {sda_in, scl_in, quick_start_pin};

   for (genvar i = 0; i < PIN_N; i++) begin : g_sync
      logic [SYNC_N-1:0] sh_r;
      logic [SYNC_N-1:0] sh_nxt;
      logic lvl_r;
      logic lvl_nxt;
      // Shift and agreement filter
      always_comb begin
         sh_nxt = {sh_r[SYNC_N-2:0], pin_in[i]};
         lvl_nxt = (sh_r[1] == sh_r[2]) ? sh_r[2] : lvl_r;
      end
      // Registers of the synchroniser
      always_ff @(posedge core_clk) begin
         if (!rst_n) begin
            sh_r <= '0;
            lvl_r <= 1'b0;
         end else if (ce) begin
            sh_r <= sh_nxt;
            lvl_r <= lvl_nxt;
         end
      end
      assign lvl_v[i] = lvl_r;
      assign rise_v[i] = lvl_nxt & ~lvl_r; // One pulse per filtered rising edge
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Register bus decode
   logic wr_ok;
   logic mode_wr;
   logic mode_qs;
   logic cfg_wr;
   logic cmd_rst;
   logic por_r;
   logic por_nxt;
   logic srst;

   // Only complete 16-bit writes count
   always_comb begin
      wr_ok = reg_wr & reg_wr_whole;
      mode_wr = wr_ok && (reg_addr == ADDR_MODE);
      mode_qs = mode_wr && (reg_wdata == MODE_QUICK_START);
      cfg_wr = wr_ok && (reg_addr == ADDR_CONFIG);
      cmd_rst = wr_ok && (reg_addr == ADDR_COMMAND) && (reg_wdata == CMD_FULL_RESET);
      por_nxt = cmd_rst;
   end

   // Full reset pulse, also withholds the acknowledge of the last byte
   always_ff @(posedge core_clk) begin
      if (!rst_n) begin
         por_r <= 1'b0;
      end else if (ce) begin
         por_r <= por_nxt;
      end
   end
   assign srst = !rst_n || (ce && por_r);

   ////////////////////////////////////////////////////////////////////////////////
   // Gauge control, alert and sleep state
   fgc_sleep_e state_r;
   fgc_sleep_e state_nxt;
   logic [CNT_W-1:0] cnt_r;
   logic [CNT_W-1:0] cnt_nxt;
   logic [DW-1:0] cfg_r;
   logic [DW-1:0] cfg_nxt;
   logic [DW-1:0] soc_r;
   logic [DW-1:0] soc_nxt;
   logic armed_r;
   logic armed_nxt;
   logic seed_r;
   logic seed_nxt;
   logic asleep;
   logic bus_low;
   logic bus_timeout;
   logic below;
   logic trig;
   logic restart;
   logic run_update;

   // Next-state logic
   always_comb begin
      asleep = (state_r != FGC_ACTIVE);
      bus_low = ~lvl_v[IN_SCL] & ~lvl_v[IN_SDA];
      bus_timeout = bus_low && (cnt_r == CNT_W'(BUS_LOW_CYC_P - 1));
      run_update = soc_update && !asleep;
      below = soc_value[DW-1:SOC_PCT_LSB] <
              {3'h0, cfg_r[CFG_THR_LSB +: CFG_THR_W]};
      trig = run_update && below && armed_r;
      restart = (rise_v[IN_QS] | mode_qs) && !asleep;
      // Bus-low timer counts only continuous low time
      if (bus_low && !asleep) begin
         cnt_nxt = (cnt_r == CNT_W'(BUS_LOW_CYC_P - 1)) ? cnt_r : cnt_r + 1'b1;
      end else begin
         cnt_nxt = '0;
      end
      // Setup register: software may clear the flag but never set it
      cfg_nxt = cfg_r;
      if (cfg_wr) begin
         cfg_nxt = reg_wdata;
         cfg_nxt[CFG_ALERT_BIT] = reg_wdata[CFG_ALERT_BIT] & cfg_r[CFG_ALERT_BIT];
      end
      if (trig) begin
         cfg_nxt[CFG_ALERT_BIT] = 1'b1; // Set wins over clear
      end
      // Re-arm on a restart, or once charge is back at or above threshold
      armed_nxt = armed_r;
      if (restart) begin
         armed_nxt = 1'b1;
      end else if (run_update) begin
         armed_nxt = !below;
      end
      soc_nxt = run_update ? soc_value : soc_r;
      // Seed from rest pending until the first conversion after a restart
      seed_nxt = seed_r;
      if (restart) begin
         seed_nxt = 1'b1;
      end else if (run_update) begin
         seed_nxt = 1'b0;
      end
      // Sleep modes
      case (state_r)
         FGC_ACTIVE: begin
            if (cfg_r[CFG_SLEEP_BIT]) begin
               state_nxt = FGC_SLEEP_SW;
            end else if (bus_timeout) begin
               state_nxt = FGC_SLEEP_BUS;
            end else begin
               state_nxt = FGC_ACTIVE;
            end
         end
         FGC_SLEEP_BUS: begin
            if (cfg_r[CFG_SLEEP_BIT]) begin
               state_nxt = FGC_SLEEP_SW;
            end else if (rise_v[IN_SCL] | rise_v[IN_SDA]) begin
               state_nxt = FGC_ACTIVE;
            end else begin
               state_nxt = FGC_SLEEP_BUS;
            end
         end
         FGC_SLEEP_SW: begin
            state_nxt = cfg_r[CFG_SLEEP_BIT] ? FGC_SLEEP_SW : FGC_ACTIVE;
         end
         default: begin
            state_nxt = FGC_ACTIVE;
         end
      endcase
   end

   // State registers; full reset restores power-up values
   always_ff @(posedge core_clk) begin
      if (srst) begin
         state_r <= FGC_ACTIVE;
         cnt_r <= '0;
         cfg_r <= CONFIG_RST;
         soc_r <= '0;
         armed_r <= 1'b1; // Armed from power-up
         seed_r <= 1'b1;
         gauge_restart <= 1'b0;
         gauge_halt <= 1'b0;
         low_charge_alert_n <= 1'b1;
      end else if (ce) begin
         state_r <= state_nxt;
         cnt_r <= cnt_nxt;
         cfg_r <= cfg_nxt;
         soc_r <= soc_nxt;
         armed_r <= armed_nxt;
         seed_r <= seed_nxt;
         gauge_restart <= restart;
         gauge_halt <= (state_nxt != FGC_ACTIVE);
         low_charge_alert_n <= ~cfg_nxt[CFG_ALERT_BIT]; // Sleep does not touch it
      end
   end
   assign gauge_seed_rest = seed_r;
   assign device_reset = por_r;
   assign reset_cmd_nack = por_r;

   ////////////////////////////////////////////////////////////////////////////////
   // Read data, valid only in the cycle after the read strobe
   logic [DW-1:0] rdata_r;
   logic [DW-1:0] rdata_nxt;

   // Read mux
   always_comb begin
      rdata_nxt = RDATA_IDLE;
      if (reg_rd) begin
         case (reg_addr)
            ADDR_SOC: rdata_nxt = soc_r;
            ADDR_CONFIG: rdata_nxt = cfg_r;
            ADDR_VERSION: rdata_nxt = VERSION_ID;
            default: rdata_nxt = RDATA_IDLE;
         endcase
      end
   end

   // Read register
   always_ff @(posedge core_clk) begin
      if (!rst_n) begin
         rdata_r <= RDATA_IDLE;
      end else if (ce) begin
         rdata_r <= rdata_nxt;
      end
   end
   assign reg_rdata = rdata_r;

   ////////////////////////////////////////////////////////////////////////////////
   // Assertions
   default clocking cb @(posedge core_clk); endclocking
   default disable iff (!rst_n);

   a_qs_pin_restart:
   assert property (ce && !por_r && rise_v[IN_QS] && !asleep |=> gauge_restart)
      else $error("quick-start edge did not restart");

   a_mode_restart:
   assert property (ce && !por_r && mode_qs && !asleep |=> gauge_restart)
      else $error("mode quick-start did not restart");

   a_mode_reserved:
   assert property (ce && !por_r && !rise_v[IN_QS] && reg_wr && !mode_qs |=> !gauge_restart)
      else $error("reserved or partial mode write restarted gauge");

   a_alert_set:
   assert property (ce && !por_r && trig |=> !low_charge_alert_n && cfg_r[CFG_ALERT_BIT])
      else $error("alert not raised on low charge");

   a_alert_hold:
   assert property (ce && !por_r && !low_charge_alert_n
                    && !(cfg_wr && !reg_wdata[CFG_ALERT_BIT]) |=> !low_charge_alert_n)
      else $error("alert released without a clear write");

   a_no_rearm_low:
   assert property (ce && !por_r && cfg_wr && !reg_wdata[CFG_ALERT_BIT] && !armed_r
                    && !restart |=> !cfg_r[CFG_ALERT_BIT] && low_charge_alert_n)
      else $error("alert re-raised while still below threshold");

   a_sleep_keeps_alert:
   assert property (ce && !por_r && !asleep && state_nxt != FGC_ACTIVE && !cfg_wr
                    && !soc_update |=> $stable(low_charge_alert_n))
      else $error("entering sleep changed the alert");

   a_halt_freezes:
   assert property (ce && !por_r && asleep |=> $stable(soc_r) && !gauge_restart
                    && (gauge_halt == asleep))
      else $error("gauge advanced while asleep");

   a_bus_wake:
   assert property (ce && !por_r && state_r == FGC_SLEEP_BUS && !cfg_r[CFG_SLEEP_BIT]
                    && (rise_v[IN_SCL] | rise_v[IN_SDA]) |=> !asleep && !gauge_halt)
      else $error("bus edge did not wake from bus sleep");

   a_sw_no_wake:
   assert property (ce && !por_r && cfg_r[CFG_SLEEP_BIT] |=> asleep && gauge_halt)
      else $error("awake while sleep bit set");

   a_bus_timer_reset:
   assert property (ce && !por_r && !bus_low |=> cnt_r == '0 ##0 state_r != FGC_SLEEP_BUS
                    || $past(state_r) == FGC_SLEEP_BUS)
      else $error("bus-low timer kept counting after a high line");

   a_full_reset:
   assert property (ce && cmd_rst |=> device_reset && reset_cmd_nack
                    ##1 (!ce || (cfg_r == CONFIG_RST && armed_r && !asleep)))
      else $error("reset command did not reset the device");

endmodule : fgc_fuel_gauge_control

// [fgc_host_model.sv]
module fgc_host_model (
   input wire logic hold_low,
   input wire logic frame,
   output logic scl,
   output logic sda
);
   timeunit 1ns;
   timeprecision 1ps;
   ////////////////////////////////////////////////////////////////
   // Host side of the two-wire bus: pulled high when idle, clocked only in frames
   initial begin
      scl = 1'b1;
      sda = 1'b1;
      #7;
      forever begin
         #80;
         if (hold_low) begin
            scl = 1'b0;
            sda = 1'b0;
         end else if (frame) begin
            scl = ~scl;
            sda = scl ? sda : ~sda;
         end else begin
            scl = 1'b1;
            sda = 1'b1;
         end
      end
   end
endmodule : fgc_host_model

// [fgc_fuel_gauge_control_tb.sv]
module fgc_fuel_gauge_control_tb;
   timeunit 1ns;
   timeprecision 1ps;
   import fgc_pkg::*;
   logic core_clk = 1'b0, rst_n = 1'b0, ce = 1'b1, reg_wr = 1'b0, reg_rd = 1'b0;
   logic reg_wr_whole = 1'b0, quick_start_pin = 1'b0, soc_update = 1'b0;
   logic [AW-1:0] reg_addr = '0;
   logic [DW-1:0] reg_wdata = '0, soc_value = '0, reg_rdata, v;
   logic scl, sda, hl = 1'b0, frame = 1'b0, rd_d = 1'b0;
   logic gauge_restart, gauge_seed_rest, gauge_halt, device_reset, nack, alert_n;
   logic [15:0] exp_q[$];
   int error_cnt = 0, check_count = 0, rs_cnt = 0, dr_cnt = 0, n;
   ////////////////////////////////////////////////////////////////
   // Clock and the parts
   initial begin
      forever #10 core_clk = ~core_clk;
   end
   fgc_host_model fgc_host_model_inst (.hold_low(hl), .frame(frame), .scl(scl), .sda(sda));
   fgc_fuel_gauge_control #(.BUS_LOW_CYC_P(50)) fgc_fuel_gauge_control_inst (
      .core_clk(core_clk), .rst_n(rst_n), .ce(ce), .reg_addr(reg_addr),
      .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_wr_whole(reg_wr_whole),
      .reg_rdata(reg_rdata), .quick_start_pin(quick_start_pin), .scl_in(scl), .sda_in(sda),
      .soc_value(soc_value), .soc_update(soc_update), .gauge_restart(gauge_restart),
      .gauge_seed_rest(gauge_seed_rest), .gauge_halt(gauge_halt),
      .device_reset(device_reset), .reset_cmd_nack(nack), .low_charge_alert_n(alert_n));
   ////////////////////////////////////////////////////////////////
   // Tasks
   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      check_count++;
      if (got !== exp) begin
         error_cnt++;
         $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : chk
   task automatic close_out;
      $display("checks=%0d errors=%0d", check_count, error_cnt);
      if (error_cnt == 0 && check_count > 0) begin
         $display("NO MISMATCHES");
      end else begin
         $display("MISMATCHES SEEN");
      end
      $finish;
   endtask : close_out
   task automatic cyc(input int k);
      repeat (k) @(posedge core_clk);
   endtask : cyc
   task automatic wr(input logic [7:0] a, input logic [15:0] d, input logic whole);
      reg_addr <= a;
      reg_wdata <= d;
      reg_wr <= 1'b1;
      reg_wr_whole <= whole;
      cyc(1);
      reg_wr <= 1'b0;
      reg_wr_whole <= 1'b0;
      cyc(1);
   endtask : wr
   task automatic rd(input logic [7:0] a, input logic [15:0] e);
      exp_q.push_back(e);
      reg_addr <= a;
      reg_rd <= 1'b1;
      cyc(1);
      reg_rd <= 1'b0;
      cyc(1);
   endtask : rd
   task automatic soc(input logic [7:0] p);
      soc_value <= {p, 8'h5A};
      soc_update <= 1'b1;
      cyc(1);
      soc_update <= 1'b0;
      cyc(1);
   endtask : soc
   task automatic wait_halt(input logic lv);
      n = 0;
      while (gauge_halt !== lv && n < 100) begin
         cyc(1);
         n++;
      end
      if (n >= 100) begin
         error_cnt++;
         close_out();
      end
   endtask : wait_halt
   ////////////////////////////////////////////////////////////////
   // Read data and pulse monitors
   always @(posedge core_clk) begin
      rd_d <= reg_rd;
      if (rd_d) begin
         chk(reg_rdata, exp_q.pop_front());
      end
      if (gauge_restart === 1'b1) rs_cnt++;
      if (device_reset === 1'b1 && nack === 1'b1) dr_cnt++;
   end
   ////////////////////////////////////////////////////////////////
   // Main sequence
   initial begin
      void'($urandom(32'h8C3B));
      cyc(6);
      rst_n <= 1'b1;
      cyc(4);
      chk({15'h0, gauge_seed_rest}, 16'h0001);
      rd(ADDR_CONFIG, CONFIG_RST);
      rd(8'h10, RDATA_IDLE);
      soc(8'h1B);
      chk({14'h0, alert_n, gauge_seed_rest}, 16'h0000);
      rd(ADDR_CONFIG, 16'h973C);
      wr(ADDR_CONFIG, 16'h971C, 1'b1);
      cyc(1);
      chk({15'h0, alert_n}, 16'h0001);
      soc(8'h10);
      chk({15'h0, alert_n}, 16'h0001);
      soc(8'h1C);
      soc(8'h05);
      chk({15'h0, alert_n}, 16'h0000);
      wr(ADDR_CONFIG, 16'h97BC, 1'b1);
      cyc(3);
      chk({14'h0, gauge_halt, alert_n}, 16'h0002);
      frame <= 1'b1;
      cyc(20);
      frame <= 1'b0;
      soc(8'h40);
      chk({14'h0, gauge_halt, alert_n}, 16'h0002);
      wr(ADDR_CONFIG, 16'h971C, 1'b1);
      cyc(3);
      chk({14'h0, gauge_halt, alert_n}, 16'h0001);
      rd(ADDR_SOC, 16'h055A);
      hl <= 1'b1;
      cyc(30);
      hl <= 1'b0;
      chk({15'h0, gauge_halt}, 16'h0000);
      cyc(10);
      hl <= 1'b1;
      wait_halt(1'b1);
      chk({15'h0, n >= 50 && n <= 64}, 16'h0001);
      hl <= 1'b0;
      wait_halt(1'b0);
      chk({15'h0, n <= 12}, 16'h0001);
      n = rs_cnt;
      quick_start_pin <= 1'b1;
      cyc(10);
      quick_start_pin <= 1'b0;
      cyc(4);
      chk(16'(rs_cnt - n), 16'h0001);
      chk({15'h0, gauge_seed_rest}, 16'h0001);
      wr(ADDR_MODE, MODE_QUICK_START, 1'b0);
      for (int i = 0; i < 4; i++) begin
         v = 16'($urandom);
         wr(ADDR_MODE, (v == MODE_QUICK_START) ? 16'h4001 : v, 1'b1);
      end
      cyc(2);
      chk(16'(rs_cnt - n), 16'h0001);
      wr(ADDR_MODE, MODE_QUICK_START, 1'b1);
      cyc(2);
      chk(16'(rs_cnt - n), 16'h0002);
      wr(ADDR_CONFIG, 16'h9705, 1'b1);
      wr(ADDR_COMMAND, CMD_FULL_RESET, 1'b0);
      wr(ADDR_COMMAND, 16'h0055, 1'b1);
      cyc(2);
      chk(16'(dr_cnt), 16'h0000);
      wr(ADDR_COMMAND, CMD_FULL_RESET, 1'b1);
      chk({14'h0, device_reset, nack}, 16'h0003);
      cyc(1);
      rd(ADDR_CONFIG, CONFIG_RST);
      rd(ADDR_VERSION, VERSION_ID);
      cyc(3);
      chk(16'(dr_cnt), 16'h0001);
      chk(16'(exp_q.size()), 16'h0000);
      close_out();
   end
endmodule : fgc_fuel_gauge_control_tb
